/* File: design/nch_pkg.sv */
// Shared constants and types for the network card host port
package nch_pkg;
    // ==========================================================
    // Widths
    localparam int ROM_CNT_W = 12;
    localparam int PAGE_W = 8;
    localparam int DATA_W = 16;
    localparam int ROM_DW = 8;
    localparam int ROM_AW = ROM_CNT_W + PAGE_W;
    localparam int IRQ_N = 4;
    // ==========================================================
    // Reset and fill values
    localparam logic [DATA_W-1:0] BUS_RST = 16'h0000;
    localparam logic [ROM_DW-1:0] ROM_HI_FILL = 8'h00;
    localparam logic [ROM_CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [ROM_CNT_W-1:0] CNT_ONE = 12'h001;
    // ==========================================================
    // Timing, in ns and derived cycles at 25 MHz
    localparam int CLK_NS = 40;
    localparam int IRQ_CLR_MAX_NS = 250;
    localparam int IRQ_CLR_CYC = (IRQ_CLR_MAX_NS / CLK_NS < 1) ? 1 : IRQ_CLR_MAX_NS / CLK_NS;
    localparam int ROM_ACC_NS = 150;
    localparam int ROM_WAIT_CYC = (ROM_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] ROM_WAIT_LD = 4'(ROM_WAIT_CYC);
    localparam logic [3:0] WAIT_ZERO = 4'h0;
    // ==========================================================
    // Host cycle states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ROM_RD,
        ST_ROM_WR,
        ST_NET_WAIT,
        ST_NET_HOLD
    } nch_state_e;
endpackage

/* File: design/nch_rom_if.sv */
// Carrier between the cycle logic and the ROM byte counter
`timescale 1ns/1ps
`default_nettype none
interface nch_rom_if;
    import nch_pkg::*;
    logic clr;
    logic inc;
    logic [ROM_CNT_W-1:0] count;
    modport ctl (output clr, output inc, input count);
    modport ctr (input clr, input inc, output count);
endinterface
`default_nettype wire

/* File: design/nch_rom_ctr.sv */
// ROM byte counter: clears on reset or ROM write, steps after each ROM read
`timescale 1ns/1ps
`default_nettype none
module nch_rom_ctr (
    input wire logic sys_clk,
    input wire logic rst,
    nch_rom_if.ctr rom
);
    import nch_pkg::*;

    logic [ROM_CNT_W-1:0] cnt_r;
    logic [ROM_CNT_W-1:0] cnt_nxt;

    // ==========================================================
    // Next count
    always_comb begin
        cnt_nxt = cnt_r;
        if (rom.clr) begin
            cnt_nxt = CNT_ZERO;
        end else if (rom.inc) begin
            cnt_nxt = cnt_r + CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign rom.count = cnt_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ctr_clear: assert property (rom.clr |=> cnt_r == CNT_ZERO)
        else $error("Counter not cleared by ROM write");
    a_ctr_step: assert property (!rom.clr && rom.inc |=> cnt_r == $past(cnt_r) + CNT_ONE)
        else $error("Counter did not step after ROM read");
    a_ctr_wrap: assert property (!rom.clr && rom.inc && cnt_r == 12'hfff |=> cnt_r == CNT_ZERO)
        else $error("Counter did not wrap to zero");
endmodule
`default_nettype wire

/* File: design/nch_host_port.sv */
// Card side of the network card host port: ROM paging, I/O cycles, interrupt, DMA
// Function
// - ROM gives byte-wide data on ROM reads
// - Twelve-bit counter drives low ROM address
// - Counter clears on reset or ROM write
// - Read returns current byte, then counter steps
// - Counter wraps after 4096 reads
// - Latched address bits select ROM page
// - N-prefixed signals are active low
// - Answer controller cycles only under chip select, or under DMA acknowledge on the DMA variant
// - Drive 16-bit data bus only on selected reads
// - Level interrupt, programmable sources, held until cleared or its source enable is dropped
// - Interrupt drops within 250 ns of clear
// - Ready pulled low stretches the cycle
// - Ready must fall early in the strobe
// - DMA handshake only on the DMA variant
// - Request high, acknowledge answers, request drop releases
`timescale 1ns/1ps
`default_nettype none
module nch_host_port #(
    parameter bit DMA_EN = 1'b0,
    parameter int IRQ_SRC = nch_pkg::IRQ_N
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic csnet_n,
    input wire logic romnet_n,
    input wire logic [nch_pkg::PAGE_W-1:0] latched_addr,
    input wire logic [nch_pkg::DATA_W-1:0] card_data_bus_in,
    output logic [nch_pkg::DATA_W-1:0] card_data_bus_out,
    output logic card_data_bus_oe_n,
    output logic ready_out,
    output logic ready_oe_n,
    output logic interrupt,
    output logic dreq,
    input wire logic dack_n,
    output logic [nch_pkg::ROM_AW-1:0] rom_addr,
    input wire logic [nch_pkg::ROM_DW-1:0] rom_data,
    output logic nc_rd,
    output logic nc_wr,
    output logic [nch_pkg::DATA_W-1:0] nc_wdata,
    input wire logic [nch_pkg::DATA_W-1:0] nc_rdata,
    input wire logic nc_ack,
    input wire logic dma_want,
    input wire logic [IRQ_SRC-1:0] irq_enable,
    input wire logic [IRQ_SRC-1:0] irq_event,
    input wire logic [IRQ_SRC-1:0] irq_clear
);
    import nch_pkg::*;

    // ==========================================================
    // Pin synchronisers, two stages
    logic [4:0] ctl_s1_r;
    logic [4:0] ctl_s2_r;
    logic [PAGE_W-1:0] la_s1_r;
    logic [PAGE_W-1:0] la_s2_r;
    logic [DATA_W-1:0] bd_s1_r;
    logic [DATA_W-1:0] bd_s2_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl_s1_r <= 5'h1f;
            ctl_s2_r <= 5'h1f;
            la_s1_r <= 8'h00;
            la_s2_r <= 8'h00;
            bd_s1_r <= BUS_RST;
            bd_s2_r <= BUS_RST;
        end else begin
            ctl_s1_r <= {dack_n, romnet_n, csnet_n, iow_n, ior_n};
            ctl_s2_r <= ctl_s1_r;
            la_s1_r <= latched_addr;
            la_s2_r <= la_s1_r;
            bd_s1_r <= card_data_bus_in;
            bd_s2_r <= bd_s1_r;
        end
    end

    logic rd;
    logic wr;
    logic net_sel;
    logic rom_sel;
    assign rd = !ctl_s2_r[0];
    assign wr = !ctl_s2_r[1];
    assign net_sel = !ctl_s2_r[2] || (DMA_EN && !ctl_s2_r[4]);
    assign rom_sel = !ctl_s2_r[3];

    // ==========================================================
    // Host cycle state
    nch_rom_if rom_bus ();
    nch_rom_ctr u_ctr (
        .sys_clk(sys_clk),
        .rst(rst),
        .rom(rom_bus)
    );

    nch_state_e st_r, st_nxt;
    logic [3:0] wait_r, wait_nxt;
    logic [DATA_W-1:0] bus_r, bus_nxt;
    logic bus_oe_n_r, bus_oe_n_nxt;
    logic rdy_oe_n_r, rdy_oe_n_nxt;
    logic nc_rd_r, nc_rd_nxt;
    logic nc_wr_r, nc_wr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [ROM_AW-1:0] rom_addr_r, rom_addr_nxt;

    always_comb begin
        st_nxt = st_r;
        wait_nxt = wait_r;
        bus_nxt = bus_r;
        bus_oe_n_nxt = 1'b1;
        rdy_oe_n_nxt = 1'b1;
        nc_rd_nxt = 1'b0;
        nc_wr_nxt = 1'b0;
        wdata_nxt = wdata_r;
        rom_bus.clr = 1'b0;
        rom_bus.inc = 1'b0;
        rom_addr_nxt = {la_s2_r, rom_bus.count};
        case (st_r)
            ST_IDLE: begin
                if (rom_sel && rd) begin
                    st_nxt = ST_ROM_RD;
                    wait_nxt = ROM_WAIT_LD;
                    rdy_oe_n_nxt = 1'b0;
                end else if (rom_sel && wr) begin
                    st_nxt = ST_ROM_WR;
                    rom_bus.clr = 1'b1;
                end else if (net_sel && (rd || wr)) begin
                    st_nxt = ST_NET_WAIT;
                    nc_rd_nxt = rd;
                    nc_wr_nxt = wr;
                    wdata_nxt = bd_s2_r;
                    // ready falls at once on strobe
                    rdy_oe_n_nxt = 1'b0;
                end
            end
            ST_ROM_RD: begin
                bus_nxt = {ROM_HI_FILL, rom_data};
                bus_oe_n_nxt = 1'b0;
                if (wait_r != WAIT_ZERO) begin
                    wait_nxt = wait_r - 4'h1;
                    rdy_oe_n_nxt = (wait_r == 4'h1);
                end
                // step at read strobe rising edge
                if (!rd) begin
                    st_nxt = ST_IDLE;
                    bus_oe_n_nxt = 1'b1;
                    rdy_oe_n_nxt = 1'b1;
                    rom_bus.inc = 1'b1;
                end
            end
            ST_ROM_WR: begin
                if (!wr) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_NET_WAIT: begin
                rdy_oe_n_nxt = 1'b0;
                if (nc_ack) begin
                    rdy_oe_n_nxt = 1'b1;
                    bus_nxt = nc_rdata;
                    bus_oe_n_nxt = !rd;
                    st_nxt = ST_NET_HOLD;
                end
            end
            ST_NET_HOLD: begin
                bus_oe_n_nxt = !(rd && net_sel);
                if (!rd && !wr) begin
                    st_nxt = ST_IDLE;
                    bus_oe_n_nxt = 1'b1;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_IDLE;
            wait_r <= WAIT_ZERO;
            bus_r <= BUS_RST;
            bus_oe_n_r <= 1'b1;
            rdy_oe_n_r <= 1'b1;
            nc_rd_r <= 1'b0;
            nc_wr_r <= 1'b0;
            wdata_r <= BUS_RST;
            rom_addr_r <= '0;
        end else begin
            st_r <= st_nxt;
            wait_r <= wait_nxt;
            bus_r <= bus_nxt;
            bus_oe_n_r <= bus_oe_n_nxt;
            rdy_oe_n_r <= rdy_oe_n_nxt;
            nc_rd_r <= nc_rd_nxt;
            nc_wr_r <= nc_wr_nxt;
            wdata_r <= wdata_nxt;
            rom_addr_r <= rom_addr_nxt;
        end
    end

    // ==========================================================
    // Interrupt pending bits, set wins over clear
    logic [IRQ_SRC-1:0] pend_r, pend_nxt;
    logic irq_r, irq_nxt;

    always_comb begin
        pend_nxt = (pend_r & ~irq_clear) | (irq_event & irq_enable);
        irq_nxt = |(pend_nxt & irq_enable);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_r <= '0;
            irq_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ==========================================================
    // DMA request, variant only
    logic dreq_r, dreq_nxt;

    always_comb begin
        dreq_nxt = 1'b0;
        if (DMA_EN) begin
            // raise on demand, drop at transfer end
            dreq_nxt = dma_want && !(st_r == ST_NET_HOLD && !rd && !wr && !ctl_s2_r[4]);
            if (dreq_r && st_r == ST_NET_HOLD && !rd && !wr) begin
                dreq_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dreq_r <= 1'b0;
        end else begin
            dreq_r <= dreq_nxt;
        end
    end

    assign card_data_bus_out = bus_r;
    assign card_data_bus_oe_n = bus_oe_n_r;
    assign ready_out = 1'b0;
    assign ready_oe_n = rdy_oe_n_r;
    assign interrupt = irq_r;
    assign dreq = dreq_r;
    assign rom_addr = rom_addr_r;
    assign nc_rd = nc_rd_r;
    assign nc_wr = nc_wr_r;
    assign nc_wdata = wdata_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_rom_read;
        st_r == ST_ROM_RD && rd;
    endsequence
    sequence s_rom_end;
        st_r == ST_ROM_RD && !rd;
    endsequence

    a_bus_only_read: assert property (!bus_oe_n_r |-> $past(rd))
        else $error("Data bus driven outside a read");
    a_rom_low_byte: assert property (s_rom_read ##1 !bus_oe_n_r |-> bus_r[15:8] == ROM_HI_FILL)
        else $error("ROM upper byte not filler");
    a_rom_step_end: assert property (s_rom_end |=> st_r == ST_IDLE && bus_oe_n_r)
        else $error("ROM read end not handled");
    a_rom_page: assert property (rom_addr_r[ROM_AW-1:ROM_CNT_W] == $past(la_s2_r))
        else $error("ROM page not from latched address");
    a_net_select: assert property ($rose(nc_rd_r) || $rose(nc_wr_r) |-> $past(net_sel))
        else $error("Controller cycle without select");
    a_ready_early: assert property (st_r == ST_IDLE && net_sel && !rom_sel && rd |=> !rdy_oe_n_r)
        else $error("Ready not pulled low at strobe start");
    a_irq_clear: assert property (irq_r && (irq_clear == pend_r) && !(|irq_event)
        |-> ##[1:6] !irq_r)
        else $error("Interrupt not removed in time");
    a_irq_hold: assert property (irq_r && !(|irq_clear) && $stable(irq_enable) |=> irq_r)
        else $error("Interrupt dropped without clear");
    a_dma_absent: assert property (!DMA_EN |-> !dreq_r)
        else $error("DMA request on non-DMA variant");
endmodule
`default_nettype wire

/* File: sim/nch_host_model.sv */
// Host motherboard I/O bus model: strobes, selects, page lines, data bus
`timescale 1ns/1ps
`default_nettype none
module nch_host_model (
    input wire logic sys_clk,
    output logic ior_n,
    output logic iow_n,
    output logic csnet_n,
    output logic romnet_n,
    output logic [nch_pkg::PAGE_W-1:0] latched_addr,
    output logic [nch_pkg::DATA_W-1:0] card_data_bus_in,
    input wire logic [nch_pkg::DATA_W-1:0] card_data_bus_out,
    input wire logic card_data_bus_oe_n,
    input wire logic ready_out,
    input wire logic ready_oe_n
);
    import nch_pkg::*;
    logic [DATA_W-1:0] host_data;
    logic [DATA_W-1:0] last_bus;
    logic host_oe;
    logic ready_wire;
    int hold_cyc;
    assign ready_wire = ready_oe_n ? 1'b1 : ready_out;
    // released bus shows a changing pattern
    assign card_data_bus_in = !card_data_bus_oe_n ? card_data_bus_out :
        host_oe ? host_data : ~last_bus;
    initial begin
        {ior_n, iow_n, csnet_n, romnet_n} = 4'hf;
        latched_addr = 8'h00;
        host_data = 16'h0000;
        host_oe = 1'b0;
        hold_cyc = 0;
        last_bus = 16'h0000;
    end
    always @(posedge sys_clk) begin
        last_bus <= card_data_bus_in;
    end
    // ==========================================================
    // One host I/O cycle
    task automatic cycle(input logic wr, input logic rom, input logic sel,
        input logic [7:0] page, input logic [15:0] wdata,
        output logic [15:0] rdata, output logic slow);
        int n;
        @(negedge sys_clk);
        latched_addr = page;
        host_data = wdata;
        @(negedge sys_clk);
        csnet_n = !(sel && !rom);
        romnet_n = !(sel && rom);
        @(negedge sys_clk);
        if (wr) begin
            iow_n = 1'b0;
            host_oe = 1'b1;
        end else begin
            ior_n = 1'b0;
        end
        n = 0;
        while (ready_wire && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        slow = (n < 8);
        n = 0;
        while (!ready_wire && n < 64) begin
            @(negedge sys_clk);
            n++;
        end
        hold_cyc = hold_cyc % 3 + 1;
        repeat (hold_cyc) @(negedge sys_clk);
        rdata = card_data_bus_in;
        ior_n = 1'b1;
        iow_n = 1'b1;
        @(negedge sys_clk);
        csnet_n = 1'b1;
        romnet_n = 1'b1;
        host_oe = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* File: sim/nch_host_port_tb_top.sv */
// Self-checking bench for the network card host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end
module nch_host_port_tb_top;
    import nch_pkg::*;
    logic sys_clk, rst, ior_n, iow_n, csnet_n, romnet_n, dack_n, dma_want;
    logic oe_n, ready_out, ready_oe_n, interrupt, dreq, nc_rd, nc_wr, nc_ack;
    logic drv_seen, slow, dma_dreq, dma_nc_wr;
    logic [15:0] dma_wdata;
    logic [7:0] latched_addr, rom_data;
    logic [15:0] bus_in, bus_out, nc_wdata, nc_rdata, wr_seen, d;
    logic [19:0] rom_addr;
    logic [3:0] irq_enable, irq_event, irq_clear;
    int n_errors, num_checks, nrd_cnt, nwr_cnt, ack_cnt;
    nch_host_port u_dut (.sys_clk(sys_clk), .rst(rst), .ior_n(ior_n), .iow_n(iow_n),
        .csnet_n(csnet_n), .romnet_n(romnet_n), .latched_addr(latched_addr),
        .card_data_bus_in(bus_in), .card_data_bus_out(bus_out), .card_data_bus_oe_n(oe_n),
        .ready_out(ready_out), .ready_oe_n(ready_oe_n), .interrupt(interrupt), .dreq(dreq),
        .dack_n(dack_n), .rom_addr(rom_addr), .rom_data(rom_data), .nc_rd(nc_rd),
        .nc_wr(nc_wr), .nc_wdata(nc_wdata), .nc_rdata(nc_rdata), .nc_ack(nc_ack),
        .dma_want(dma_want), .irq_enable(irq_enable), .irq_event(irq_event),
        .irq_clear(irq_clear));
    nch_host_model u_host (.sys_clk(sys_clk), .ior_n(ior_n), .iow_n(iow_n),
        .csnet_n(csnet_n), .romnet_n(romnet_n), .latched_addr(latched_addr),
        .card_data_bus_in(bus_in), .card_data_bus_out(bus_out), .card_data_bus_oe_n(oe_n),
        .ready_out(ready_out), .ready_oe_n(ready_oe_n));
    // DMA variant, addressed by acknowledge only
    nch_host_port #(.DMA_EN(1'b1)) u_dma (.sys_clk(sys_clk), .rst(rst), .ior_n(ior_n),
        .iow_n(iow_n), .csnet_n(1'b1), .romnet_n(1'b1), .latched_addr(latched_addr),
        .card_data_bus_in(bus_in), .card_data_bus_out(), .card_data_bus_oe_n(),
        .ready_out(), .ready_oe_n(), .interrupt(), .dreq(dma_dreq), .dack_n(dack_n),
        .rom_addr(), .rom_data(rom_data), .nc_rd(), .nc_wr(dma_nc_wr), .nc_wdata(dma_wdata),
        .nc_rdata(nc_rdata), .nc_ack(nc_ack), .dma_want(dma_want), .irq_enable(irq_enable),
        .irq_event(irq_event), .irq_clear(irq_clear));
    function automatic logic [7:0] rom_byte(input logic [19:0] a);
        return a[7:0] ^ a[19:12] ^ {a[11:8], 4'h3};
    endfunction
    assign rom_data = rom_byte(rom_addr);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ==========================================================
    // Controller stand-in and bus monitor
    always @(negedge sys_clk) begin
        if (nc_wr) begin
            nwr_cnt++;
            wr_seen = nc_wdata;
        end
        if (nc_rd) nrd_cnt++;
        if (nc_rd || nc_wr || dma_nc_wr) ack_cnt = 3;
        else if (ack_cnt > 0) ack_cnt--;
        nc_ack = (ack_cnt == 1);
        if (!oe_n) drv_seen = 1'b1;
    end
    task automatic report_and_stop;
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic rom_rd(input logic [7:0] pg, input logic [11:0] cnt);
        u_host.cycle(1'b0, 1'b1, 1'b1, pg, 16'h0000, d, slow);
        `CHK(d, {ROM_HI_FILL, rom_byte({pg, cnt})})
        `CHK(slow, 1'b1)
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        `CHK({oe_n, ready_oe_n, interrupt, dreq}, 4'hc)
        `CHK(rom_addr, 20'h00000)
        `CHK(ready_out, 1'b0)
    endtask
    task automatic t_rom_wrap;
        u_host.cycle(1'b1, 1'b1, 1'b1, 8'h3c, 16'h5555, d, slow);
        for (int i = 0; i <= 4096; i++) rom_rd(8'h3c, 12'(i));
        // count returns to zero after a full page
        `CHK(rom_addr, {8'h3c, 12'h001})
        `CHK(nwr_cnt + nrd_cnt, 0)
    endtask
    task automatic t_rom_clear;
        rom_rd(8'hff, 12'h001);
        rom_rd(8'hff, 12'h002);
        `CHK(rom_addr, {8'hff, 12'h003})
        u_host.cycle(1'b1, 1'b1, 1'b1, 8'hff, 16'hffff, d, slow);
        rom_rd(8'h81, 12'h000);
        `CHK(rom_addr[19:12], 8'h81)
        do_reset();
        rom_rd(8'h81, 12'h000);
        `CHK(rom_addr, {8'h81, 12'h001})
    endtask
    task automatic t_net;
        drv_seen = 1'b0;
        u_host.cycle(1'b1, 1'b0, 1'b1, 8'h00, 16'h1234, d, slow);
        `CHK(nwr_cnt, 1)
        `CHK(wr_seen, 16'h1234)
        `CHK(drv_seen, 1'b0)
        u_host.cycle(1'b0, 1'b0, 1'b1, 8'h00, 16'h0000, d, slow);
        `CHK(d, nc_rdata)
        `CHK(slow, 1'b1)
        drv_seen = 1'b0;
        u_host.cycle(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000, d, slow);
        `CHK(slow, 1'b0)
        u_host.cycle(1'b1, 1'b0, 1'b0, 8'h00, 16'h4321, d, slow);
        `CHK(drv_seen, 1'b0)
        `CHK(nrd_cnt + nwr_cnt, 2)
    endtask
    task automatic t_irq;
        irq_enable = 4'h1;
        irq_event = 4'h1;
        @(negedge sys_clk);
        irq_event = 4'h0;
        repeat (3) @(negedge sys_clk);
        `CHK(interrupt, 1'b1)
        repeat (10) @(negedge sys_clk);
        `CHK(interrupt, 1'b1)
        irq_clear = 4'h1;
        @(negedge sys_clk);
        irq_clear = 4'h0;
        repeat (IRQ_CLR_CYC - 1) @(negedge sys_clk);
        `CHK(interrupt, 1'b0)
        irq_enable = 4'hb;
        irq_event = 4'h4;
        @(negedge sys_clk);
        irq_event = 4'h0;
        repeat (4) @(negedge sys_clk);
        `CHK(interrupt, 1'b0)
        // Event and clear together: set wins
        irq_event = 4'h1;
        irq_clear = 4'h1;
        @(negedge sys_clk);
        {irq_event, irq_clear} = 8'h00;
        repeat (2) @(negedge sys_clk);
        `CHK(interrupt, 1'b1)
    endtask
    task automatic t_dma;
        dma_want = 1'b1;
        repeat (2) @(negedge sys_clk);
        `CHK(dma_dreq, 1'b1)
        dack_n = 1'b0;
        u_host.cycle(1'b1, 1'b0, 1'b0, 8'h00, 16'h5a5a, d, slow);
        `CHK(dma_wdata, 16'h5a5a)
        `CHK(dreq, 1'b0)
        `CHK(nrd_cnt + nwr_cnt, 2)
        dma_want = 1'b0;
        @(negedge sys_clk);
        `CHK(dma_dreq, 1'b0)
        dack_n = 1'b1;
    endtask
    initial begin
        {n_errors, num_checks, nrd_cnt, nwr_cnt, ack_cnt} = '0;
        {rst, dack_n, dma_want, nc_ack, drv_seen} = 5'h18;
        nc_rdata = 16'hc3a5;
        {irq_enable, irq_event, irq_clear} = 12'h000;
        do_reset();
        t_reset();
        t_rom_wrap();
        t_rom_clear();
        t_net();
        t_irq();
        t_dma();
        report_and_stop();
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
